// ==== rtl/isf_pkg.sv ====
// Shared constants, field positions and carrier types of the bus status flag block.
package isf_pkg;

   // Register address and reset value of the bus status register.
   localparam logic [15:0] ISF_STATUS_ADDR  = 16'hffb5;
   localparam logic [7:0]  ISF_STATUS_RESET = 8'h00;

   // Bit positions inside the bus status register.
   localparam int ISF_BIT_MASTER     = 7;
   localparam int ISF_BIT_ARB_LOST   = 6;
   localparam int ISF_BIT_EXT_CODE   = 5;
   localparam int ISF_BIT_ADDR_MATCH = 4;
   localparam int ISF_BIT_TX_DIR     = 3;
   localparam int ISF_BIT_ACK        = 2;
   localparam int ISF_BIT_START      = 1;
   localparam int ISF_BIT_STOP       = 0;

   // Extension code patterns in the upper four address bits.
   localparam logic [3:0] ISF_EXT_CODE_LOW  = 4'h0;
   localparam logic [3:0] ISF_EXT_CODE_HIGH = 4'hf;

   // Serial clock edge numbers inside one byte.
   localparam logic [3:0] ISF_ADDR_LAST_CLOCK = 4'h8;
   localparam logic [3:0] ISF_ACK_CLOCK       = 4'h9;

   // Wait cycles inserted into every status read.
   localparam int ISF_READ_WAIT_CYCLES = 1;

   // Status flags in register bit order, bit 7 first.
   typedef struct packed {
      logic master_active_flag;
      logic arbitration_lost_flag;
      logic extension_code_flag;
      logic address_match_flag;
      logic transmit_direction_flag;
      logic ack_detected_flag;
      logic start_detected_flag;
      logic stop_detected_flag;
   } isf_flags_t;

   // Events seen on the serial bus; start, stop and the clock rises are one-cycle pulses.
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       clk_rise;
      logic       first_rise;
      logic       eighth_rise;
      logic       ninth_rise;
      logic       first_byte;
      logic       data_bit;
      logic [7:0] rx_byte;
   } isf_bus_evt_t;

endpackage

// ==== rtl/isf_bus_monitor.sv ====
// Serial bus watcher: synchronises the pins and reports conditions and clock edges.
`timescale 1ns/1ps
module isf_bus_monitor
   import isf_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic         enable_i,
   input  wire logic         serial_clock_line_i,
   input  wire logic         serial_data_line_i,
   output isf_bus_evt_t      evt_o
);

   logic [1:0]   scl_sync;
   logic [1:0]   sda_sync;
   logic         scl_prev;
   logic         sda_prev;
   logic [3:0]   clk_count;
   logic [3:0]   next_clk_count;
   logic         first_byte;
   logic         next_first_byte;
   logic [7:0]   shift;
   logic [7:0]   next_shift;
   isf_bus_evt_t next_evt;

   // Two flip-flop synchronisers; only the second stage is used by logic.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], serial_clock_line_i};
         sda_sync <= {sda_sync[0], serial_data_line_i};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
      end
   end

   // Detects start, stop and clock edges and counts clocks inside each byte.
   always_comb begin
      next_evt        = '0;
      next_clk_count  = clk_count;
      next_first_byte = first_byte;
      next_shift      = shift;
      next_evt.data_bit = sda_sync[1];
      if (enable_i) begin
         if (scl_sync[1] && scl_prev && sda_prev && !sda_sync[1]) begin
            next_evt.start  = 1'b1;
            next_clk_count  = 4'h0;
            next_first_byte = 1'b1;
         end else if (scl_sync[1] && scl_prev && !sda_prev && sda_sync[1]) begin
            next_evt.stop   = 1'b1;
            next_clk_count  = 4'h0;
            next_first_byte = 1'b0;
         end else if (scl_sync[1] && !scl_prev) begin
            next_evt.clk_rise   = 1'b1;
            next_evt.first_rise = (clk_count == 4'h0);
            next_clk_count      = clk_count + 4'h1;
            if (clk_count < ISF_ADDR_LAST_CLOCK) begin
               next_shift = {shift[6:0], sda_sync[1]};
            end
            next_evt.eighth_rise = (next_clk_count == ISF_ADDR_LAST_CLOCK);
            next_evt.ninth_rise  = (next_clk_count == ISF_ACK_CLOCK);
            if (next_clk_count == ISF_ACK_CLOCK) begin
               next_clk_count = 4'h0;
            end
         end
         if (evt_o.ninth_rise) begin
            next_first_byte = 1'b0; // The byte after the first is data.
         end
      end else begin
         next_clk_count  = 4'h0;
         next_first_byte = 1'b0;
      end
      next_evt.first_byte = first_byte;
      next_evt.rx_byte    = next_shift;
   end

   // Registers the bus tracking state and the event pulses.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_count  <= 4'h0;
         first_byte <= 1'b0;
         shift      <= 8'h00;
         evt_o      <= '0;
      end else begin
         clk_count  <= next_clk_count;
         first_byte <= next_first_byte;
         shift      <= next_shift;
         evt_o      <= next_evt;
      end
   end

endmodule

// ==== rtl/i2c_status_flags.sv ====
// Bus status flag register of the serial bus interface with its CPU read port.
//
// Overview of operation
// RQ1 - Reset clears the whole status register.
// RQ2 - Software reads only with start trigger, in wait.
// RQ3 - Every status read is stretched by one wait.
// RQ4 - Software never reads with peripheral clock stopped.
// RQ5 - Generated start sets master active, bit seven.
// RQ6 - Stop, loss, exit or disable clear master.
// RQ7 - Lost arbitration sets bit six.
// RQ8 - Read, disable or reset clears arbitration loss.
// RQ9 - Any single bit read clears arbitration loss.
// RQ10 - Upper nibble 0000 or 1111 sets bit five.
// RQ11 - Matching slave address sets bit four.
// RQ12 - Start, stop, exit or disable clear five, four.
// RQ13 - Transmit direction drives data line from latch.
// RQ14 - Low ninth clock sets acknowledge; next byte clears.
// RQ15 - CPU writes leave every flag unchanged.
`timescale 1ns/1ps
module i2c_status_flags
   import isf_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic        cpu_rd_i,
   input  wire logic        cpu_wr_i,
   output logic      [7:0]  cpu_rdata_o,
   output logic             cpu_wait_o,
   output logic             cpu_ack_o,
   input  wire logic        operation_enable_i,
   input  wire logic        exit_communication_i,
   input  wire logic        wait_release_i,
   input  wire logic        start_generated_i,
   input  wire logic        serial_output_latch_i,
   input  wire logic [7:0]  local_slave_address_i,
   input  wire logic        serial_clock_line_i,
   input  wire logic        serial_data_line_i,
   output logic             serial_data_line_o,
   output logic             serial_data_line_oe_n_o,
   output isf_flags_t       status_o
);

   // Read port states.
   typedef enum logic [0:0] {
      RD_IDLE,
      RD_WAIT
   } isf_rd_state_t;

   isf_rd_state_t rd_state;
   isf_rd_state_t next_rd_state;
   isf_flags_t    flags;
   isf_flags_t    next_flags;
   isf_bus_evt_t  evt;
   logic [7:0]    next_rdata;
   logic          next_wait;
   logic          next_ack;
   logic          read_done;
   logic          enable_q;
   logic          enable_fall;
   logic          comm_clear;
   logic          arb_loss;
   logic          addr_match;
   logic          ext_code;
   logic          next_sda;
   logic          next_sda_oe_n;

   // True when the upper address bits form an extension code.
   function automatic logic is_ext_code(input logic [7:0] addr_byte);
      is_ext_code = (addr_byte[7:4] == ISF_EXT_CODE_LOW) ||
                    (addr_byte[7:4] == ISF_EXT_CODE_HIGH);
   endfunction

   // True when the seven address bits equal the local slave address.
   function automatic logic is_own_addr(input logic [7:0] addr_byte,
                                        input logic [7:0] own);
      is_own_addr = (addr_byte[7:1] == own[7:1]);
   endfunction

   // Watches the serial pins and reports bus events.
   isf_bus_monitor u_bus_monitor (
      .clk_sys_i           (clk_sys_i),
      .rst_n_i             (rst_n_i),
      .enable_i            (operation_enable_i),
      .serial_clock_line_i (serial_clock_line_i),
      .serial_data_line_i  (serial_data_line_i),
      .evt_o               (evt)
   );

   // Event decoding shared by the flag logic.
   assign enable_fall = enable_q && !operation_enable_i;
   assign comm_clear  = exit_communication_i || enable_fall;
   assign read_done   = (rd_state == RD_WAIT);
   assign ext_code    = is_ext_code(evt.rx_byte);
   assign addr_match  = is_own_addr(evt.rx_byte, local_slave_address_i);
   // A released high bit that reads back low means another master won.
   assign arb_loss    = evt.clk_rise && flags.master_active_flag &&
                        flags.transmit_direction_flag && serial_output_latch_i &&
                        !evt.data_bit; // RQ7

   // Read port: one wait cycle, then data and acknowledge; writes are answered only.
   always_comb begin
      next_rd_state = rd_state;
      next_rdata    = cpu_rdata_o;
      next_wait     = 1'b0;
      next_ack      = 1'b0;
      unique case (rd_state)
         RD_IDLE: begin
            if (cpu_rd_i && (cpu_addr_i == ISF_STATUS_ADDR)) begin
               next_rd_state = RD_WAIT;
               next_wait     = 1'b1; // RQ3
            end else if (cpu_wr_i && (cpu_addr_i == ISF_STATUS_ADDR)) begin
               next_ack = 1'b1; // RQ15
            end
         end
         RD_WAIT: begin
            next_rd_state = RD_IDLE;
            next_rdata    = flags;
            next_ack      = 1'b1; // RQ3
         end
      endcase
   end

   // Registers the read port outputs.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_state    <= RD_IDLE;
         cpu_rdata_o <= ISF_STATUS_RESET;
         cpu_wait_o  <= 1'b0;
         cpu_ack_o   <= 1'b0;
      end else begin
         rd_state    <= next_rd_state;
         cpu_rdata_o <= next_rdata;
         cpu_wait_o  <= next_wait;
         cpu_ack_o   <= next_ack;
      end
   end

   // Flag updates: clears are applied first so a coincident set wins.
   always_comb begin
      next_flags = flags;

      // Master activity.
      if (evt.stop || arb_loss || comm_clear) begin
         next_flags.master_active_flag = 1'b0; // RQ6
      end
      if (start_generated_i) begin
         next_flags.master_active_flag = 1'b1; // RQ5
      end

      // Arbitration loss; every kind of status read clears it.
      if (read_done || enable_fall) begin
         next_flags.arbitration_lost_flag = 1'b0; // RQ8 RQ9
      end
      if (arb_loss) begin
         next_flags.arbitration_lost_flag = 1'b1; // RQ7
      end

      // Extension code and address match of the first byte.
      if (evt.start || evt.stop || comm_clear) begin
         next_flags.extension_code_flag = 1'b0; // RQ12
         next_flags.address_match_flag  = 1'b0; // RQ12
      end
      if (evt.eighth_rise && evt.first_byte && ext_code) begin
         next_flags.extension_code_flag = 1'b1; // RQ10
      end
      if (evt.eighth_rise && evt.first_byte && addr_match) begin
         next_flags.address_match_flag = 1'b1; // RQ11
      end

      // Transfer direction.
      if (evt.stop || comm_clear || arb_loss || evt.start ||
          (wait_release_i && flags.transmit_direction_flag)) begin
         next_flags.transmit_direction_flag = 1'b0;
      end
      if (evt.eighth_rise && evt.first_byte) begin
         if (flags.master_active_flag) begin
            next_flags.transmit_direction_flag = !evt.rx_byte[0];
         end else begin
            next_flags.transmit_direction_flag = addr_match && evt.rx_byte[0];
         end
      end
      if (start_generated_i) begin
         next_flags.transmit_direction_flag = 1'b1;
      end

      // Acknowledge detection.
      if (evt.first_rise || evt.stop || comm_clear) begin
         next_flags.ack_detected_flag = 1'b0; // RQ14
      end
      if (evt.ninth_rise && !evt.data_bit) begin
         next_flags.ack_detected_flag = 1'b1; // RQ14
      end

      // Start and stop condition seen.
      if (evt.stop || comm_clear) begin
         next_flags.start_detected_flag = 1'b0;
      end
      if (evt.start) begin
         next_flags.start_detected_flag = 1'b1;
      end
      if (evt.start || comm_clear) begin
         next_flags.stop_detected_flag = 1'b0;
      end
      if (evt.stop) begin
         next_flags.stop_detected_flag = 1'b1;
      end
   end

   // Data line drive follows the transfer direction flag.
   always_comb begin
      next_sda      = serial_output_latch_i; // RQ13
      next_sda_oe_n = !next_flags.transmit_direction_flag; // RQ13
   end

   // Registers the flags, the enable history and the data line drive.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags                   <= ISF_STATUS_RESET; // RQ1
         status_o                <= ISF_STATUS_RESET; // RQ1
         enable_q                <= 1'b0;
         serial_data_line_o      <= 1'b1;
         serial_data_line_oe_n_o <= 1'b1;
      end else begin
         flags                   <= next_flags;
         status_o                <= next_flags;
         enable_q                <= operation_enable_i;
         serial_data_line_o      <= next_sda;
         serial_data_line_oe_n_o <= next_sda_oe_n;
      end
   end

endmodule

// ==== testbench/isf_chk.sv ====
// Port checker of the bus status flag block.
`timescale 1ns/1ps
module isf_chk
   import isf_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_n_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic        cpu_rd_i,
   input wire logic        cpu_wr_i,
   input wire logic [7:0]  cpu_rdata_o,
   input wire logic        cpu_wait_o,
   input wire logic        cpu_ack_o,
   input wire logic        operation_enable_i,
   input wire logic        exit_communication_i,
   input wire logic        start_generated_i,
   input wire logic        serial_output_latch_i,
   input wire logic        serial_data_line_o,
   input wire logic        serial_data_line_oe_n_o,
   input wire isf_flags_t  status_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // A read is taken when the port is idle and the mapped address is given.
   sequence s_take;
      cpu_rd_i && cpu_addr_i == ISF_STATUS_ADDR && !cpu_wait_o;
   endsequence
   sequence s_answer;
      cpu_wait_o && !cpu_ack_o ##1 cpu_ack_o && !cpu_wait_o;
   endsequence

   property p_read_wait;
      s_take |=> s_answer;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read not stretched once");
   property p_read_clear;
      s_take ##1 cpu_wait_o |=> !status_o.arbitration_lost_flag;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("loss kept after read");
   property p_rdata;
      cpu_ack_o && $past(cpu_wait_o) |-> cpu_rdata_o == $past(status_o);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data differs from flags");
   property p_write;
      cpu_wr_i && !cpu_rd_i && cpu_addr_i == ISF_STATUS_ADDR && !cpu_wait_o
         |=> cpu_ack_o && !cpu_wait_o;
   endproperty
   a_write: assert property (p_write) else $error("write not answered");
   property p_start;
      start_generated_i && operation_enable_i |=> ##[0:1] status_o.master_active_flag;
   endproperty
   a_start: assert property (p_start) else $error("master flag not set");
   property p_exit;
      exit_communication_i |-> ##[1:2]
         {status_o.master_active_flag, status_o[5:4]} == 3'h0;
   endproperty
   a_exit: assert property (p_exit) else $error("exit left flags set");
   property p_disable;
      $fell(operation_enable_i) |-> ##[1:2] status_o[7:4] == 4'h0;
   endproperty
   a_disable: assert property (p_disable) else $error("disable left flags set");
   property p_loss;
      $rose(status_o.arbitration_lost_flag) |-> ##[0:1] !status_o.master_active_flag;
   endproperty
   a_loss: assert property (p_loss) else $error("master kept after loss");
   property p_drive;
      $rose(status_o.transmit_direction_flag) |-> ##[0:1]
         !serial_data_line_oe_n_o && serial_data_line_o == serial_output_latch_i;
   endproperty
   a_drive: assert property (p_drive) else $error("data line not driven");
   property p_release;
      $fell(status_o.transmit_direction_flag) |-> ##[0:1] serial_data_line_oe_n_o;
   endproperty
   a_release: assert property (p_release) else $error("data line not released");
endmodule

bind i2c_status_flags isf_chk isf_chk_inst (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
   .cpu_wr_i(cpu_wr_i), .cpu_rdata_o(cpu_rdata_o), .cpu_wait_o(cpu_wait_o),
   .cpu_ack_o(cpu_ack_o), .operation_enable_i(operation_enable_i),
   .exit_communication_i(exit_communication_i), .start_generated_i(start_generated_i),
   .serial_output_latch_i(serial_output_latch_i), .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe_n_o(serial_data_line_oe_n_o), .status_o(status_o));

// ==== testbench/isf_bus_party.sv ====
// Model of another bus party that frames bytes on the open-drain clock and data lines.
`timescale 1ns/1ps
module isf_bus_party (
   input  wire logic clk_sys_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Both lines rest released to the pull-up between frames.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic half(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Data falls while the clock is high, then the clock is pulled low.
   task automatic start_cond();
      sda_o <= 1'b0;
      half(8);
      scl_o <= 1'b0;
      half(4);
   endtask
   // Eight bits first bit highest, then the acknowledge slot; data moves only with clock low.
   task automatic send_byte(input logic [7:0] b, input logic ack);
      logic [8:0] v;
      v = {b, !ack};
      for (int i = 8; i >= 0; i--) begin
         sda_o <= v[i];
         half(4);
         scl_o <= 1'b1;
         half(8);
         scl_o <= 1'b0;
         half(4);
      end
   endtask
   // Data rises while the clock is high.
   task automatic stop_cond();
      sda_o <= 1'b0;
      half(4);
      scl_o <= 1'b1;
      half(8);
      sda_o <= 1'b1;
      half(8);
   endtask
endmodule

// ==== testbench/i2c_status_flags_bench.sv ====
// Self-checking bench of the bus status flag block with a model bus party.
`timescale 1ns/1ps
module i2c_status_flags_bench;
   import isf_pkg::*;
   logic        clk_sys_i, rst_n_i, cpu_rd_i, cpu_wr_i, enable, exit_comm, start_gen;
   logic [15:0] cpu_addr_i;
   logic [7:0]  rdata, got, d;
   logic        wait_o, ack_o, sda_out, oe_n, scl, party_sda;
   logic [1:0]  hs;
   logic        wrel, latch;
   isf_flags_t  st;
   int          bad_count, checked, cyc;
   // Rows: address byte, acknowledge given, then expected extension, match, acknowledge.
   logic [11:0] rows [5] = '{12'ha4b, 12'h09d, 12'hf24, 12'h529, 12'ha5b};
   wire         sda = party_sda & (oe_n | sda_out);

   i2c_status_flags i2c_status_flags_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
      .cpu_wr_i(cpu_wr_i), .cpu_rdata_o(rdata), .cpu_wait_o(wait_o), .cpu_ack_o(ack_o),
      .operation_enable_i(enable), .exit_communication_i(exit_comm), .wait_release_i(wrel),
      .start_generated_i(start_gen), .serial_output_latch_i(latch),
      .local_slave_address_i(8'ha4), .serial_clock_line_i(scl), .serial_data_line_i(sda),
      .serial_data_line_o(sda_out), .serial_data_line_oe_n_o(oe_n), .status_o(st));
   isf_bus_party isf_bus_party_inst (.clk_sys_i(clk_sys_i), .scl_o(scl), .sda_o(party_sda));

   // Clock of 25 ns period.
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // Cuts a hang short.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // Read held until the edge after the wait, then released.
   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys_i);
      cpu_addr_i <= a;
      cpu_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      #1 hs[1] = wait_o;
      @(posedge clk_sys_i);
      cpu_rd_i <= 1'b0;
      #1 hs[0] = ack_o;
      got = rdata;
   endtask
   task automatic wr();
      @(posedge clk_sys_i);
      cpu_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      cpu_wr_i <= 1'b0;
      #1 hs[0] = ack_o;
   endtask
   // One-cycle pulse of start generated (s high) or exit (s low).
   task automatic pulse(input logic s);
      @(posedge clk_sys_i);
      start_gen <= s;
      exit_comm <= !s;
      @(posedge clk_sys_i);
      start_gen <= 1'b0;
      exit_comm <= 1'b0;
   endtask

   // Main sequence: reset, table of frames, then hand-written cases.
   initial begin
      {cpu_rd_i, cpu_wr_i, enable, exit_comm, start_gen, wrel, bad_count, checked, cyc} = '0;
      latch = 1'b1;
      cpu_addr_i = ISF_STATUS_ADDR;
      rst_n_i = 1'b0;
      tick(12);
      chk("reset status", ISF_STATUS_RESET, st);
      chk("reset drive", 8'h01, {7'h0, oe_n});
      @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      enable  <= 1'b1;
      foreach (rows[i]) begin
         isf_bus_party_inst.start_cond();
         isf_bus_party_inst.send_byte(rows[i][11:4], rows[i][3]);
         tick(2);
         chk("frame flags", {5'h0, rows[i][2:0]}, {5'h0, st[5:4], st[2]});
         chk("frame dir", {7'h0, rows[i][1] & rows[i][4]}, {7'h0, ~oe_n});
         isf_bus_party_inst.stop_cond();
         tick(2);
         chk("stop clear", 8'h00, {6'h0, st[5:4]});
      end
      pulse(1'b1);
      tick(2);
      chk("master set", 8'h01, {7'h0, st[7]});
      d = st;
      wr();
      chk("write ack", 8'h01, {7'h0, hs[0]});
      tick(2);
      chk("write keeps", d, st);
      rd(ISF_STATUS_ADDR);
      chk("read hs", 8'h03, {6'h0, hs});
      chk("read data", d, got);
      rd(16'hffb4);
      chk("unmapped hs", 8'h00, {6'h0, hs});
      pulse(1'b0);
      tick(2);
      chk("exit clear", 8'h00, {7'h0, st[7]});
      isf_bus_party_inst.start_cond();
      pulse(1'b1);
      isf_bus_party_inst.send_byte(8'h00, 1'b0);
      tick(2);
      chk("loss flags", 8'h01, {6'h0, st[7:6]});
      rd(ISF_STATUS_ADDR);
      chk("loss read", 8'h01, {7'h0, got[6]});
      tick(1);
      chk("loss clear", 8'h00, {7'h0, st[6]});
      isf_bus_party_inst.stop_cond();
      isf_bus_party_inst.start_cond();
      isf_bus_party_inst.send_byte(8'ha4, 1'b1);
      pulse(1'b1);
      tick(2);
      chk("pre disable", 8'h03, {6'h0, st[7], st[4]});
      // A low latch must reach the data line while the direction flag drives it.
      @(posedge clk_sys_i);
      latch <= 1'b0;
      tick(2);
      chk("latch drive", 8'h00, {6'h0, sda_out, oe_n});
      // A wait release while transmitting drops the direction flag and frees the line.
      @(posedge clk_sys_i);
      wrel <= 1'b1;
      @(posedge clk_sys_i);
      wrel <= 1'b0;
      tick(2);
      chk("release drive", 8'h01, {7'h0, oe_n});
      @(posedge clk_sys_i);
      enable <= 1'b0;
      tick(3);
      chk("disable clear", 8'h00, {4'h0, st[7:4]});
      end_sim();
   end
endmodule
